// file: adc_out_pkg.sv
// What this block does
// R1 - Three output modes; serial register or serial clock pin level picks the mode.
// R2 - Parallel programming cannot reach the double-data-rate single-ended mode.
// R3 - Full-rate mode drives all 16 sample bits plus true and complement clocks.
// R4 - DDR single-ended mode puts two sample bits on each of 8 lines.
// R5 - DDR differential mode uses 8 data pairs and a clock pair.
// R6 - Stabilizer accepts 30 to 70 percent duty, makes 50 percent internal clock.
// R7 - Stabilizer needs one hundred encode cycles to lock after change or stop.
// R8 - Stabilizer enable comes from clock control bit or chip-select pin level.
// R9 - Controller keeps stabilizer off below 5Msps.
// R10 - Clock source keeps negative encode input above 200mV in differential mode.
// R11 - Optional features are written into the mode control registers over SPI.
// R12 - A conversion starts on each rising edge of the positive encode input.
// R13 - Full-rate data change with the falling edge of the true output clock.
// R14 - Parallel mode: serial clock pin low gives full-rate, high gives differential.
// R15 - DDR modes: even bits while true clock low, odd bits while high.
// R16 - Both halves of a sample fit one encode period; clock toggles per half.
// R17 - Receiver rebuilds each sample from low-phase and high-phase captures.
package adc_out_pkg;
  typedef enum logic [1:0]
  {
    MODE_FULL = 2'b00,
    MODE_DDR_SE = 2'b01,
    MODE_DDR_DIFF = 2'b11
  } out_mode_t;
  localparam int CORE_CLK_NS = 40;
  localparam int SAMPLE_WIDTH = 16;
  localparam int DDR_LINES = 8;
  localparam int PERIOD_WIDTH = 8;
  localparam logic [PERIOD_WIDTH-1:0] STOP_LIMIT = 8'hff;
  localparam int LOCK_ENCODE_CYCLES = 100;
  localparam logic [6:0] LOCK_COUNT = 7'(LOCK_ENCODE_CYCLES);
  localparam logic [PERIOD_WIDTH-1:0] PERIOD_TOLERANCE = 8'h01;
  localparam logic [PERIOD_WIDTH-1:0] MIN_PERIOD = 8'h02;
endpackage

// file: duty_stabilizer.sv
`timescale 1ns/1ns
`default_nettype none
module duty_stabilizer
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enc_rise,
  input wire logic enc_level,
  input wire logic enable,
  output logic samp_clk,
  output logic locked
);
  logic [adc_out_pkg::PERIOD_WIDTH-1:0] cnt_reg;
  logic [adc_out_pkg::PERIOD_WIDTH-1:0] period_reg;
  logic [adc_out_pkg::PERIOD_WIDTH-1:0] period_next;
  logic [adc_out_pkg::PERIOD_WIDTH-1:0] diff;
  logic [6:0] lock_reg;
  logic stopped;
  logic changed;
  logic regen_reg;

  assign period_next = cnt_reg + 8'h01;
  assign diff = (period_next > period_reg) ? period_next - period_reg : period_reg - period_next;
  assign stopped = (cnt_reg == adc_out_pkg::STOP_LIMIT);
  assign changed = diff > adc_out_pkg::PERIOD_TOLERANCE;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      period_reg <= '0;
    end
    else if (enc_rise)
    begin
      cnt_reg <= '0;
      period_reg <= period_next;
    end
    else if (!stopped)
    begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // Lock restarts on a period jump or a stopped clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lock_reg <= '0;
    end
    else if (!enable || stopped)
    begin
      lock_reg <= '0; // see R7
    end
    else if (enc_rise)
    begin
      if (changed)
      begin
        lock_reg <= '0; // see R7
      end
      else if (lock_reg != adc_out_pkg::LOCK_COUNT)
      begin
        lock_reg <= lock_reg + 7'h01; // see R7
      end
    end
  end

  // High for the first half of the measured period whatever the input duty
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      regen_reg <= 1'b0;
    end
    else if (enc_rise)
    begin
      regen_reg <= 1'b1; // see R6
    end
    else if (period_reg < adc_out_pkg::MIN_PERIOD || cnt_reg + 8'h01 >= (period_reg >> 1))
    begin
      regen_reg <= 1'b0; // see R6
    end
  end

  assign samp_clk = enable ? regen_reg : enc_level; // see R6
  assign locked = enable && (lock_reg == adc_out_pkg::LOCK_COUNT); // see R7
endmodule
`default_nettype wire

// file: adc_output_mode_and_clock_stabilizer.sv
`timescale 1ns/1ns
`default_nettype none
module adc_output_mode_and_clock_stabilizer
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PROG_MODE_SELECT,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic CHIP_SELECT_PIN,
  input wire logic [1:0] OUTPUT_MODE_REG,
  input wire logic CLOCK_CONTROL_DCS_EN,
  input wire logic ENCODE_POS,
  input wire logic ENCODE_NEG,
  input wire logic [15:0] SAMPLE_IN,
  output logic [15:0] SAMPLE_BITS,
  output logic [7:0] DDR_LINES,
  output logic [7:0] DDR_PAIR_P,
  output logic [7:0] DDR_PAIR_N,
  output logic DATA_OUT_CLOCK_TRUE,
  output logic DATA_OUT_CLOCK_COMP,
  output logic [1:0] ACTIVE_MODE,
  output logic DCS_ENABLED,
  output logic DCS_LOCKED,
  output logic ENCODE_SINGLE_ENDED,
  output logic SAMPLE_STROBE
);
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic enc_prev_reg;
  logic enc_rise;
  logic parallel;
  logic dcs_en;
  logic samp_clk;
  logic samp_prev_reg;
  logic samp_rise;
  logic samp_fall;
  logic [15:0] captured_reg;
  logic [15:0] word_reg;
  logic [7:0] half_reg;
  logic [7:0] half_next;
  adc_out_pkg::out_mode_t mode;

  function automatic adc_out_pkg::out_mode_t pick_mode(input logic par, input logic pin, input logic [1:0] reg_val);
    adc_out_pkg::out_mode_t m;
    m = adc_out_pkg::MODE_FULL;
    if (par)
    begin
      m = pin ? adc_out_pkg::MODE_DDR_DIFF : adc_out_pkg::MODE_FULL; // see R14 see R2
    end
    else
    begin
      case (reg_val)
        2'b01: m = adc_out_pkg::MODE_DDR_SE;
        2'b11: m = adc_out_pkg::MODE_DDR_DIFF;
        default: m = adc_out_pkg::MODE_FULL;
      endcase
    end
    return m;
  endfunction

  // Pins from outside the core domain pass two flip-flops
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= {ENCODE_NEG, ENCODE_POS, CHIP_SELECT_PIN, SERIAL_CLOCK_PIN, PROG_MODE_SELECT};
      sync_reg <= meta_reg;
    end
  end

  assign parallel = sync_reg[0];
  assign mode = pick_mode(parallel, sync_reg[1], OUTPUT_MODE_REG); // see R1 see R11
  assign dcs_en = parallel ? sync_reg[2] : CLOCK_CONTROL_DCS_EN; // see R8
  assign enc_rise = sync_reg[3] && !enc_prev_reg;

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      enc_prev_reg <= 1'b0;
      samp_prev_reg <= 1'b0;
    end
    else
    begin
      enc_prev_reg <= sync_reg[3];
      samp_prev_reg <= samp_clk;
    end
  end

  duty_stabilizer u_dcs
  (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .enc_rise(enc_rise),
    .enc_level(sync_reg[3]),
    .enable(dcs_en),
    .samp_clk(samp_clk),
    .locked(DCS_LOCKED)
  );

  assign samp_rise = samp_clk && !samp_prev_reg;
  assign samp_fall = !samp_clk && samp_prev_reg;

  // Conversion result is taken on the encode rising edge
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      captured_reg <= '0;
    end
    else if (enc_rise)
    begin
      captured_reg <= SAMPLE_IN; // see R12
    end
  end

  // One word per internal period; both halves fit inside it
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      word_reg <= '0;
    end
    else if (samp_rise)
    begin
      word_reg <= captured_reg; // see R16
    end
  end

  // Clock low in the first half, high in the second half
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      DATA_OUT_CLOCK_TRUE <= 1'b0;
      DATA_OUT_CLOCK_COMP <= 1'b1;
    end
    else if (samp_rise)
    begin
      DATA_OUT_CLOCK_TRUE <= 1'b0; // see R13 see R16
      DATA_OUT_CLOCK_COMP <= 1'b1; // see R3 see R4
    end
    else if (samp_fall)
    begin
      DATA_OUT_CLOCK_TRUE <= 1'b1; // see R16
      DATA_OUT_CLOCK_COMP <= 1'b0; // see R5
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      SAMPLE_BITS <= '0;
    end
    else if (samp_rise)
    begin
      SAMPLE_BITS <= (mode == adc_out_pkg::MODE_FULL) ? captured_reg : 16'h0000; // see R3 see R13
    end
  end

  // Even bit on the internal rise, odd bit from the held word on the fall
  // The chosen half is held here, apart from the mode gating below
  for (genvar g = 0; g < adc_out_pkg::DDR_LINES; g++)
  begin
    assign half_next[g] = samp_rise ? captured_reg[2*g] : (samp_fall ? word_reg[2*g+1] : half_reg[g]); // see R15
  end

  // Gated by mode on every edge, so a mode switch never leaves a pair half driven
  // Unused lines of the other modes are held low to keep switching noise down
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      half_reg <= '0;
      DDR_LINES <= '0;
      DDR_PAIR_P <= '0;
      DDR_PAIR_N <= '0;
    end
    else
    begin
      half_reg <= half_next;
      DDR_LINES <= (mode == adc_out_pkg::MODE_DDR_SE) ? half_next : 8'h00; // see R4 see R15
      DDR_PAIR_P <= (mode == adc_out_pkg::MODE_DDR_DIFF) ? half_next : 8'h00; // see R5 see R15
      DDR_PAIR_N <= (mode == adc_out_pkg::MODE_DDR_DIFF) ? ~half_next : 8'h00; // see R5
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ACTIVE_MODE <= adc_out_pkg::MODE_FULL;
      DCS_ENABLED <= 1'b0;
      SAMPLE_STROBE <= 1'b0;
    end
    else
    begin
      ACTIVE_MODE <= mode; // see R1
      DCS_ENABLED <= dcs_en; // see R8
      SAMPLE_STROBE <= samp_rise;
    end
  end

  // A differential pair is never low on both inputs; a grounded complement is
  // Limitation: skew between the two sync paths may set it briefly; a high complement clears it
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ENCODE_SINGLE_ENDED <= 1'b0;
    end
    else if (!sync_reg[4] && !sync_reg[3])
    begin
      ENCODE_SINGLE_ENDED <= 1'b1; // see R10
    end
    else if (sync_reg[4])
    begin
      ENCODE_SINGLE_ENDED <= 1'b0; // see R10
    end
  end
endmodule
`default_nettype wire

// file: adc_out_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module adc_out_monitor
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PROG_MODE_SELECT,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic CHIP_SELECT_PIN,
  input wire logic [1:0] OUTPUT_MODE_REG,
  input wire logic CLOCK_CONTROL_DCS_EN,
  input wire logic [15:0] SAMPLE_BITS,
  input wire logic [7:0] DDR_PAIR_P,
  input wire logic [7:0] DDR_PAIR_N,
  input wire logic DATA_OUT_CLOCK_TRUE,
  input wire logic DATA_OUT_CLOCK_COMP,
  input wire logic [1:0] ACTIVE_MODE,
  input wire logic DCS_ENABLED,
  input wire logic SAMPLE_STROBE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  // Five cycles cover the two sync stages and the mode register
  AST_COMP: assert property (DATA_OUT_CLOCK_COMP == !DATA_OUT_CLOCK_TRUE)
    else $error("output clock pair not complementary");
  AST_PAIR_N: assert property (ACTIVE_MODE == adc_out_pkg::MODE_DDR_DIFF |-> DDR_PAIR_N == ~DDR_PAIR_P)
    else $error("data pair halves not inverse");
  AST_PAR_NO_SE: assert property (PROG_MODE_SELECT [*5] |-> ACTIVE_MODE != adc_out_pkg::MODE_DDR_SE)
    else $error("single-ended ddr reached in parallel mode");
  AST_PAR_DIFF: assert property ((PROG_MODE_SELECT && SERIAL_CLOCK_PIN) [*5] |->
    ACTIVE_MODE == adc_out_pkg::MODE_DDR_DIFF) else $error("pin did not pick differential");
  AST_SER_SE: assert property ((!PROG_MODE_SELECT && OUTPUT_MODE_REG == 2'h1) [*5] |->
    ACTIVE_MODE == adc_out_pkg::MODE_DDR_SE) else $error("register did not pick ddr");
  AST_DCS_PAR: assert property ((PROG_MODE_SELECT && CHIP_SELECT_PIN) [*5] |-> DCS_ENABLED)
    else $error("select pin did not enable stabilizer");
  AST_DCS_SER: assert property ((!PROG_MODE_SELECT && !CLOCK_CONTROL_DCS_EN) [*5] |-> !DCS_ENABLED)
    else $error("stabilizer on with bit clear");
  AST_FULL_EDGE: assert property (ACTIVE_MODE == adc_out_pkg::MODE_FULL && SAMPLE_BITS != 16'h0000 &&
    $changed(SAMPLE_BITS) |-> $fell(DATA_OUT_CLOCK_TRUE)) else $error("full data moved off clock fall");
  AST_STROBE: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE)
    else $error("sample strobe longer than one cycle");
  cover property (ACTIVE_MODE == adc_out_pkg::MODE_DDR_SE);
  cover property (ACTIVE_MODE == adc_out_pkg::MODE_DDR_DIFF);
  cover property (DCS_ENABLED && SAMPLE_STROBE);
endmodule
bind adc_output_mode_and_clock_stabilizer adc_out_monitor u_adc_out_monitor
(.CORE_CLK, .SYS_RST, .PROG_MODE_SELECT, .SERIAL_CLOCK_PIN, .CHIP_SELECT_PIN, .OUTPUT_MODE_REG,
 .CLOCK_CONTROL_DCS_EN, .SAMPLE_BITS, .DDR_PAIR_P, .DDR_PAIR_N, .DATA_OUT_CLOCK_TRUE,
 .DATA_OUT_CLOCK_COMP, .ACTIVE_MODE, .DCS_ENABLED, .SAMPLE_STROBE);
`default_nettype wire

// file: adc_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
module adc_rx_model
(
  input wire logic clk,
  input wire logic ddr_sel,
  input wire logic clk_true,
  input wire logic [15:0] full_bits,
  input wire logic [7:0] lines,
  output logic [15:0] word
);
  logic clk_prev;
  logic [15:0] full_prev;
  logic [7:0] lines_prev;
  logic [7:0] even;
  // Previous-cycle values stand in for capture on the forwarded edge
  always_ff @(posedge clk)
  begin
    clk_prev <= clk_true;
    full_prev <= full_bits;
    lines_prev <= lines;
    if (clk_true && !clk_prev)
    begin
      even <= lines_prev;
      if (!ddr_sel)
        word <= full_prev;
    end
    if (!clk_true && clk_prev && ddr_sel)
      for (int i = 0; i < 8; i++)
        word[2*i +: 2] <= {lines_prev[i], even[i]};
  end
endmodule
`default_nettype wire

// file: test_adc_output_mode_and_clock_stabilizer.sv
`timescale 1ns/1ns
`default_nettype none
module test_adc_output_mode_and_clock_stabilizer;
  logic clk = 0, rst = 1, par = 0, sck = 0, cs = 0, dcs = 0, enc = 0, run = 1, se = 0, ddr = 0;
  logic [1:0] mreg = 2'h0;
  logic [15:0] din = 16'h0000;
  logic [15:0] bits, word;
  logic [7:0] lines, pp, pn;
  logic ct, cc, dcs_on, locked, single, strobe;
  logic [1:0] mode;
  int mismatches = 0, comparisons = 0, hi_ns = 160, n;
  initial forever #20 clk = ~clk;
  // Encode period stands for full rate on the scaled core clock, above the stabilizer floor
  initial
  begin
    @(negedge clk);
    forever
    begin
      #(320 - hi_ns) enc = run;
      #(hi_ns) enc = 0;
    end
  end
  adc_output_mode_and_clock_stabilizer u_adc_output_mode_and_clock_stabilizer
  (.CORE_CLK(clk), .SYS_RST(rst), .PROG_MODE_SELECT(par), .SERIAL_CLOCK_PIN(sck), .CHIP_SELECT_PIN(cs),
   .OUTPUT_MODE_REG(mreg), .CLOCK_CONTROL_DCS_EN(dcs), .ENCODE_POS(enc), .ENCODE_NEG(se ? 1'b0 : !enc),
   .SAMPLE_IN(din), .SAMPLE_BITS(bits), .DDR_LINES(lines), .DDR_PAIR_P(pp), .DDR_PAIR_N(pn),
   .DATA_OUT_CLOCK_TRUE(ct), .DATA_OUT_CLOCK_COMP(cc), .ACTIVE_MODE(mode), .DCS_ENABLED(dcs_on),
   .DCS_LOCKED(locked), .ENCODE_SINGLE_ENDED(single), .SAMPLE_STROBE(strobe));
  adc_rx_model u_adc_rx_model
  (.clk(clk), .ddr_sel(ddr), .clk_true(ct), .full_bits(bits), .lines(lines | pp), .word(word));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cfg(input logic p, s, c, input logic [1:0] m, input logic d);
    @(negedge clk);
    {par, sck, cs, mreg, dcs} = {p, s, c, m, d};
    repeat (6) @(negedge clk);
  endtask
  task automatic xfer(input logic [15:0] v, input logic [1:0] m);
    ddr = (m != adc_out_pkg::MODE_FULL);
    din = v;
    repeat (48) @(negedge clk);
    check(mode, m);
    check(word, v);
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 0;
    cfg(0, 0, 0, 2'h0, 0);
    xfer(16'ha5c3, adc_out_pkg::MODE_FULL);
    check(single, 1'b0);
    cfg(0, 0, 0, 2'h1, 0);
    xfer(16'h3c96, adc_out_pkg::MODE_DDR_SE);
    cfg(0, 0, 0, 2'h3, 0);
    xfer(16'h5a0f, adc_out_pkg::MODE_DDR_DIFF);
    check({8'h00, pn}, {8'h00, ~pp});
    cfg(0, 0, 0, 2'h2, 0);
    xfer(16'h0ff0, adc_out_pkg::MODE_FULL);
    cfg(1, 0, 0, 2'h1, 0);
    xfer(16'hc33c, adc_out_pkg::MODE_FULL);
    hi_ns = 120;
    cfg(1, 1, 1, 2'h1, 0);
    check(dcs_on, 1'b1);
    xfer(16'h9669, adc_out_pkg::MODE_DDR_DIFF);
    for (n = 0; n < 20 && ct !== 1'b0; n++)
      @(negedge clk);
    for (n = 0; n < 20 && ct !== 1'b1; n++)
      @(negedge clk);
    for (n = 0; n < 20 && ct === 1'b1; n++)
      @(negedge clk);
    check(16'(n), 16'(320 / (2 * adc_out_pkg::CORE_CLK_NS)));
    cfg(0, 0, 0, 2'h0, 0);
    check(dcs_on, 1'b0);
    cfg(0, 0, 0, 2'h0, 1);
    for (n = 0; n < 1200 && locked !== 1'b1; n++)
      @(negedge clk);
    check(n > 760 && n < 1200, 1'b1);
    run = 0;
    repeat (300) @(negedge clk);
    check(locked, 1'b0);
    run = 1;
    se = 1;
    repeat (12) @(negedge clk);
    check(single, 1'b1);
    test_done;
  end
endmodule
`default_nettype wire
